/* include/lcgc_consts.vh */
`ifndef LCGC_CONSTS_VH
`define LCGC_CONSTS_VH

// Cluster geometry
`define LCGC_NUM_CELLS 8
`define LCGC_NUM_GLOBAL_NET_BUFFER 8
`define LCGC_NUM_GPIN 6
`define LCGC_LUT_INPUTS 4
`define LCGC_LUT_SIZE 16
`define LCGC_GLUT_SLOTS 4

// Register addresses (word index on the plain register port)
`define LCGC_ADDR_W 8
`define LCGC_ADDR_CTRL 8'h00
`define LCGC_ADDR_CLKSEL 8'h01
`define LCGC_ADDR_GBSRC 8'h02
`define LCGC_ADDR_LUTG 8'h03
`define LCGC_ADDR_CELLCFG 8'h04
`define LCGC_ADDR_STATUS 8'h05
`define LCGC_ADDR_LUT_BASE 8'h08
`define LCGC_LUT_PAGE 5'h01
`define LCGC_LUT_PAGE_RANGE 7:3
`define LCGC_LUT_IDX_RANGE 2:0

// CTRL fields
`define LCGC_CTRL_DONE 0
`define LCGC_CTRL_SYNC 1
`define LCGC_CTRL_SRUSE 2
`define LCGC_CTRL_CEUSE 3

// CLKSEL fields
`define LCGC_CLK_IDX 2:0
`define LCGC_CLK_FABRIC 3
`define LCGC_SR_PAIR 5:4
`define LCGC_SR_GLOBAL_NET_BUFFER 6
`define LCGC_CE_PAIR 8:7
`define LCGC_CE_GLOBAL_NET_BUFFER 9
`define LCGC_CLKSEL_W 10
`define LCGC_CLKSEL_RST 10'h008

// CELLCFG fields
`define LCGC_CFG_REGOUT 7:0
`define LCGC_CFG_CARRY 15:8
`define LCGC_CFG_SRSET 23:16
`define LCGC_CFG_OE 31:24

// STATUS fields
`define LCGC_ST_OUT 7:0
`define LCGC_ST_Q 15:8
`define LCGC_ST_COUT 16
`define LCGC_ST_DONE 17

// Global buffers fed from on-chip strobe sources
`define LCGC_GLOBAL_NET_BUFFER_SLOW 4
`define LCGC_GLOBAL_NET_BUFFER_FAST 5

`endif

/* logic/lcgc_cell.v */
`include "lcgc_consts.vh"

module lcgc_cell (
  // Clock and resets
  input wire clk,
  input wire rst_n,
  input wire glb_rst,
  // Shared cluster controls
  input wire tick,
  input wire ce,
  input wire sr,
  input wire sr_async,
  // Cell configuration
  input wire [15:0] lut_init,
  input wire reg_out_sel,
  input wire carry_mode,
  input wire sr_set,
  // Data
  input wire [3:0] lut_in,
  input wire carry_in,
  output wire cell_out,
  output wire carry_out,
  output reg q
);
  wire [3:0] idx;
  wire lut;

  // Top input taken from the carry chain in arithmetic mode
  assign idx = {(carry_mode ? carry_in : lut_in[3]), lut_in[2:0]};
  assign lut = lut_init[idx];
  // Majority carry, as for a full adder on inputs 1 and 2
  assign carry_out = (lut_in[1] & lut_in[2]) | (lut_in[1] & carry_in) |
                     (lut_in[2] & carry_in);
  assign cell_out = reg_out_sel ? q : lut;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (glb_rst) begin
      // Wake-up state is reset whatever the set/reset variant
      q <= 1'b0;
    end else if (sr && sr_async) begin
      q <= sr_set;
    end else if (tick) begin
      if (sr) begin
        q <= sr_set;
      end else if (ce) begin
        q <= lut;
      end
    end
  end
endmodule

/* logic/lcgc_top.v */
`include "lcgc_consts.vh"

module lcgc_top #(
  parameter NUM_CELLS = `LCGC_NUM_CELLS
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // Register port
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // Global input pins and strobe sources
  input wire [5:0] GPIN,
  input wire SLOW_PULSE,
  input wire FAST_PULSE,
  output wire [5:0] GPIN_FREE,
  // Fabric side
  input wire [4*NUM_CELLS-1:0] LUT_IN,
  input wire FABRIC_CLK,
  input wire FABRIC_CE,
  input wire FABRIC_SR,
  input wire CARRY_CHAIN_IN,
  output wire [NUM_CELLS-1:0] CELL_OUT,
  output wire CARRY_CHAIN_OUT,
  // User I/O drive
  output wire [NUM_CELLS-1:0] USER_IO_OUT,
  output wire [NUM_CELLS-1:0] USER_IO_OE,
  // Configuration-time controls
  output wire GLOBAL_RESET,
  output wire IO_FLOAT_CONTROL
);
  // Reset release
  reg rst_q1;
  reg rst_q2;
  wire rst_n;

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  assign rst_n = rst_q2;

  // Buffer bit selected by a three-bit index
  function pick8;
    input [7:0] v;
    input [2:0] i;
    begin
      pick8 = v[i];
    end
  endfunction

  // Configuration registers
  reg cfg_done;
  reg sr_sync;
  reg sr_use;
  reg ce_use;
  reg [`LCGC_CLKSEL_W-1:0] clksel;
  reg [7:0] gbsrc;
  reg [15:0] lutg;
  reg [31:0] cellcfg;
  reg [15:0] lut_init [0:NUM_CELLS-1];

  wire lut_page;
  wire [2:0] lut_idx;
  integer k;

  assign lut_page = (ADDR[`LCGC_LUT_PAGE_RANGE] == `LCGC_LUT_PAGE);
  assign lut_idx = ADDR[`LCGC_LUT_IDX_RANGE];

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done <= 1'b0;
      sr_sync <= 1'b0;
      sr_use <= 1'b0;
      ce_use <= 1'b0;
      clksel <= `LCGC_CLKSEL_RST;
      gbsrc <= 8'h00;
      lutg <= 16'h0000;
      cellcfg <= 32'h00000000;
      for (k = 0; k < NUM_CELLS; k = k + 1) begin
        lut_init[k] <= 16'h0000;
      end
    end else if (WR) begin
      if (ADDR == `LCGC_ADDR_CTRL) begin
        // Completion is one-way until the next reset
        cfg_done <= cfg_done | WDATA[`LCGC_CTRL_DONE];
        sr_sync <= WDATA[`LCGC_CTRL_SYNC];
        sr_use <= WDATA[`LCGC_CTRL_SRUSE];
        ce_use <= WDATA[`LCGC_CTRL_CEUSE];
      end
      if (ADDR == `LCGC_ADDR_CLKSEL) begin
        clksel <= WDATA[`LCGC_CLKSEL_W-1:0];
      end
      if (ADDR == `LCGC_ADDR_GBSRC) begin
        gbsrc <= WDATA[7:0];
      end
      if (ADDR == `LCGC_ADDR_LUTG) begin
        lutg <= WDATA[15:0];
      end
      if (ADDR == `LCGC_ADDR_CELLCFG) begin
        cellcfg <= WDATA;
      end
      if (lut_page && ({29'h0, lut_idx} < NUM_CELLS)) begin
        lut_init[lut_idx] <= WDATA[15:0];
      end
    end
  end

  // Global controls: both held during configuration, dropped together
  assign GLOBAL_RESET = ~cfg_done;
  assign IO_FLOAT_CONTROL = ~cfg_done;

  // Global buffers
  wire [7:0] global_net_buffer;
  assign global_net_buffer = {gbsrc[7] & GPIN[5], gbsrc[6] & GPIN[4], FAST_PULSE, SLOW_PULSE,
                 gbsrc[3:0] & GPIN[3:0]};

  // A pin is busy only while its buffer is the cluster clock
  wire clk_from_global_net_buffer;
  wire [2:0] clk_idx;
  assign clk_from_global_net_buffer = ~clksel[`LCGC_CLK_FABRIC];
  assign clk_idx = clksel[`LCGC_CLK_IDX];

  genvar p;
  generate
    for (p = 0; p < `LCGC_NUM_GPIN; p = p + 1) begin : g_pin
      // Pins 4 and 5 skip the two strobe-fed buffers
      localparam integer BUF_NUM = (p < 4) ? p : p + 2;
      localparam [2:0] BUF = BUF_NUM[2:0];
      assign GPIN_FREE[p] = ~(clk_from_global_net_buffer && clk_idx == BUF && gbsrc[BUF]);
    end
  endgenerate

  // Cluster clock: one core clock, so the selected source becomes a tick
  wire clk_src;
  reg clk_src_q;
  wire tick;
  assign clk_src = clk_from_global_net_buffer ? pick8(global_net_buffer, clk_idx) : FABRIC_CLK;

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clk_src_q <= 1'b0;
    end else begin
      clk_src_q <= clk_src;
    end
  end
  assign tick = clk_src & ~clk_src_q;

  // Shared set/reset and clock enable
  wire sr_src;
  wire ce_src;
  wire sr;
  wire ce;
  assign sr_src = clksel[`LCGC_SR_GLOBAL_NET_BUFFER] ?
                  pick8(global_net_buffer, {clksel[`LCGC_SR_PAIR], 1'b0}) : FABRIC_SR;
  assign ce_src = clksel[`LCGC_CE_GLOBAL_NET_BUFFER] ?
                  pick8(global_net_buffer, {clksel[`LCGC_CE_PAIR], 1'b1}) : FABRIC_CE;
  // Unused set/reset never disturbs the flip-flops
  assign sr = sr_use & sr_src;
  assign ce = ce_use ? ce_src : 1'b1;

  // Global buffer slots onto table inputs: one slot per input position
  wire [3:0] slot_en;
  wire [3:0] slot_val;
  genvar s;
  generate
    for (s = 0; s < `LCGC_GLUT_SLOTS; s = s + 1) begin : g_slot
      assign slot_en[s] = lutg[4*s+3];
      assign slot_val[s] = pick8(global_net_buffer, lutg[4*s+2:4*s]);
    end
  endgenerate

  // Cells and carry chain
  wire [NUM_CELLS:0] carry;
  wire [NUM_CELLS-1:0] q;
  assign carry[0] = CARRY_CHAIN_IN;

  genvar c;
  generate
    for (c = 0; c < NUM_CELLS; c = c + 1) begin : g_cell
      wire [3:0] lin;
      assign lin = (slot_en & slot_val) | (~slot_en & LUT_IN[4*c+3:4*c]);
      lcgc_cell u_cell (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .glb_rst(GLOBAL_RESET),
        .tick(tick),
        .ce(ce),
        .sr(sr),
        .sr_async(~sr_sync),
        .lut_init(lut_init[c]),
        .reg_out_sel(cellcfg[c]),
        .carry_mode(cellcfg[8+c]),
        .sr_set(cellcfg[16+c]),
        .lut_in(lin),
        .carry_in(carry[c]),
        .cell_out(CELL_OUT[c]),
        .carry_out(carry[c+1]),
        .q(q[c])
      );
      // User pins float while the device is configuring
      assign USER_IO_OE[c] = cellcfg[24+c] & ~IO_FLOAT_CONTROL;
    end
  endgenerate

  assign CARRY_CHAIN_OUT = carry[NUM_CELLS];
  assign USER_IO_OUT = CELL_OUT;

  // Read port: data stands one cycle after the strobe, zero elsewhere
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    if (ADDR == `LCGC_ADDR_CTRL) begin
      next_rdata[`LCGC_CTRL_DONE] = cfg_done;
      next_rdata[`LCGC_CTRL_SYNC] = sr_sync;
      next_rdata[`LCGC_CTRL_SRUSE] = sr_use;
      next_rdata[`LCGC_CTRL_CEUSE] = ce_use;
    end else if (ADDR == `LCGC_ADDR_CLKSEL) begin
      next_rdata[`LCGC_CLKSEL_W-1:0] = clksel;
    end else if (ADDR == `LCGC_ADDR_GBSRC) begin
      next_rdata[7:0] = gbsrc;
    end else if (ADDR == `LCGC_ADDR_LUTG) begin
      next_rdata[15:0] = lutg;
    end else if (ADDR == `LCGC_ADDR_CELLCFG) begin
      next_rdata = cellcfg;
    end else if (ADDR == `LCGC_ADDR_STATUS) begin
      next_rdata[`LCGC_ST_OUT] = CELL_OUT;
      next_rdata[`LCGC_ST_Q] = q;
      next_rdata[`LCGC_ST_COUT] = CARRY_CHAIN_OUT;
      next_rdata[`LCGC_ST_DONE] = cfg_done;
    end else if (lut_page && ({29'h0, lut_idx} < NUM_CELLS)) begin
      next_rdata[15:0] = lut_init[lut_idx];
    end
  end

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule

/* test/lcgc_monitor.sv */
module lcgc_monitor #(
  parameter NUM_CELLS = 8
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // Register port
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  // Cell and I/O side
  input wire [NUM_CELLS-1:0] CELL_OUT,
  input wire [NUM_CELLS-1:0] USER_IO_OUT,
  input wire [NUM_CELLS-1:0] USER_IO_OE,
  input wire GLOBAL_RESET,
  input wire IO_FLOAT_CONTROL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire done_wr = WR && ADDR == 8'h00 && WDATA[0];
  pair_release_a:
    assert property (GLOBAL_RESET == IO_FLOAT_CONTROL) else $error("reset and float differ");
  float_no_drive_a:
    assert property (IO_FLOAT_CONTROL |-> USER_IO_OE == '0) else $error("drive while floating");
  io_mirror_a:
    assert property (USER_IO_OUT == CELL_OUT) else $error("io out differs from cell");
  reset_held_a:
    assert property (GLOBAL_RESET && !done_wr |=> GLOBAL_RESET) else $error("reset dropped");
  reset_stays_off_a:
    assert property (!GLOBAL_RESET |=> !GLOBAL_RESET) else $error("reset came back");
  done_release_a:
    assert property (done_wr |=> !GLOBAL_RESET && !IO_FLOAT_CONTROL) else $error("no release");
  wake_cleared_a:
    assert property (GLOBAL_RESET && RD && ADDR == 8'h05 |=> RDATA[15:8] == 8'h00)
      else $error("flops not cleared");
  done_status_a:
    assert property (RD && ADDR == 8'h05 |=> RDATA[17] == !$past(GLOBAL_RESET))
      else $error("done bit wrong");
endmodule

bind lcgc_top lcgc_monitor #(.NUM_CELLS(NUM_CELLS)) u_monitor (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CELL_OUT(CELL_OUT), .USER_IO_OUT(USER_IO_OUT), .USER_IO_OE(USER_IO_OE),
  .GLOBAL_RESET(GLOBAL_RESET), .IO_FLOAT_CONTROL(IO_FLOAT_CONTROL));

/* test/lcgc_fabric.sv */
module lcgc_fabric (
  // Clock
  input wire clk,
  // Request from bench
  input wire tick_req,
  // Fabric clock and strobes
  output logic fab_clk,
  output logic slow_pulse,
  output logic fast_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt = 6'h00;
  initial {fab_clk, slow_pulse, fast_pulse} = 3'h0;
  always @(posedge clk) begin
    cnt <= cnt + 6'h01;
    // One-cycle high, so each request is one clean edge
    fab_clk <= tick_req;
    slow_pulse <= cnt == 6'h3f;
    fast_pulse <= cnt[0];
  end
endmodule

/* test/tb_logic_cluster_global_control.sv */
module tb_logic_cluster_global_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0;
  logic ce = 1'b0, sr = 1'b0, cin = 1'b0, fclk, slow, fast, cout, grst, flt;
  logic [7:0] addr = '0, q, cell_out, io_out, oe;
  logic [31:0] wdata = '0, lut_in = '0, rdata, v, x;
  logic [15:0] init [8];
  logic [5:0] gpin = '0, gfree;
  integer seed = 32'hec39, mismatches = 0, tests_run = 0, i;
  always #5 clk = ~clk;
  lcgc_fabric fab (.clk(clk), .tick_req(req), .fab_clk(fclk), .slow_pulse(slow),
    .fast_pulse(fast));
  lcgc_top dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .GPIN(gpin), .SLOW_PULSE(slow), .FAST_PULSE(fast), .GPIN_FREE(gfree),
    .LUT_IN(lut_in), .FABRIC_CLK(fclk), .FABRIC_CE(ce), .FABRIC_SR(sr), .CARRY_CHAIN_IN(cin),
    .CELL_OUT(cell_out), .CARRY_CHAIN_OUT(cout), .USER_IO_OUT(io_out), .USER_IO_OE(oe),
    .GLOBAL_RESET(grst), .IO_FLOAT_CONTROL(flt));
  function logic [7:0] lut_out(input logic [31:0] a);
    for (int c = 0; c < 8; c++)
      lut_out[c] = init[c][a[4*c+:4]];
  endfunction
  function logic carry_exp(input logic [31:0] a, input logic k);
    for (int c = 0; c < 8; c++)
      k = (a[4*c+1] & a[4*c+2]) | (k & (a[4*c+1] | a[4*c+2]));
    return k;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // New table inputs, then one fabric clock edge
  task pulse(input logic e, input logic s);
    @(posedge clk);
    x = $random(seed);
    lut_in <= x;
    ce <= e;
    sr <= s;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 8; i++)
      init[i] = $random(seed);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h05);
    chk({v[17], v[15:8]}, 9'h0);
    chk({grst, flt, oe, gfree}, 16'hc03f);
    for (i = 0; i < 8; i++)
      wr_reg(8'h08 + i[7:0], {16'h0, init[i]});
    wr_reg(8'h04, 32'hff00_0000);
    #1 chk(oe, 8'h00);
    wr_reg(8'h00, 32'h1);
    #1 chk({grst, flt, oe}, 10'h0ff);
    rd_reg(8'h07);
    chk(v, 32'h0);
    repeat (16) begin
      x = $random(seed);
      @(posedge clk);
      lut_in <= x;
      #1 chk(cell_out, lut_out(x));
    end
    wr_reg(8'h04, 32'hff00_ff00);
    repeat (16) begin
      x = $random(seed);
      @(posedge clk);
      lut_in <= x;
      cin <= x[31];
      #1 chk(cout, carry_exp(x, x[31]));
    end
    wr_reg(8'h04, 32'hff00_00ff);
    wr_reg(8'h00, 32'h8);
    pulse(1'b1, 1'b0);
    q = lut_out(x);
    chk(cell_out, q);
    pulse(1'b0, 1'b0);
    chk(cell_out, q);
    wr_reg(8'h00, 32'h0);
    pulse(1'b0, 1'b1);
    chk(cell_out, lut_out(x));
    sr <= 1'b0;
    wr_reg(8'h04, 32'hfff0_00ff);
    wr_reg(8'h00, 32'h4);
    sr <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(cell_out, 8'hf0);
    @(posedge clk);
    sr <= 1'b0;
    wr_reg(8'h04, 32'hff0f_00ff);
    wr_reg(8'h00, 32'h6);
    sr <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(cell_out, 8'hf0);
    pulse(1'b1, 1'b1);
    chk(cell_out, 8'h0f);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h02, 32'h1);
    wr_reg(8'h01, 32'h0);
    #1 chk(gfree, 6'h3e);
    x = $random(seed);
    @(posedge clk);
    lut_in <= x;
    gpin <= 6'h01;
    repeat (3) @(posedge clk);
    #1 chk(cell_out, lut_out(x));
    rd_reg(8'h05);
    chk({v[17], v[15:8]}, {1'b1, lut_out(x)});
    q = lut_out(x);
    // Set/reset from buffer 6 only; buffer 7 must not reach it
    sr <= 1'b0;
    wr_reg(8'h02, 32'hcf);
    wr_reg(8'h01, 32'h78);
    wr_reg(8'h04, 32'h005a_00ff);
    wr_reg(8'h00, 32'h4);
    gpin <= 6'h20;
    repeat (3) @(posedge clk);
    #1 chk(cell_out, q);
    gpin <= 6'h10;
    repeat (3) @(posedge clk);
    #1 chk(cell_out, 8'h5a);
    // Clock enable from buffer 7 only; buffer 6 must not reach it
    wr_reg(8'h01, 32'h388);
    wr_reg(8'h00, 32'h8);
    pulse(1'b1, 1'b0);
    chk(cell_out, 8'h5a);
    gpin <= 6'h20;
    pulse(1'b0, 1'b0);
    chk(cell_out, lut_out(x));
    wr_reg(8'h04, 32'hff00_0000);
    wr_reg(8'h01, 32'h6);
    #1 chk(gfree, 6'h2f);
    wr_reg(8'h01, 32'h4);
    #1 chk(gfree, 6'h3f);
    // One slot: buffer 1 replaces input 0 of every cell
    wr_reg(8'h03, 32'h9);
    repeat (8) begin
      x = $random(seed);
      v = $random(seed);
      @(posedge clk);
      lut_in <= x;
      gpin <= v[5:0];
      x = (x & ~32'h11111111) | ({32{v[1]}} & 32'h11111111);
      #1 chk(cell_out, lut_out(x));
    end
    // Four slots: buffers 1, 4, 5, 6; long enough to see the slow strobe
    wr_reg(8'h03, 32'hedc9);
    repeat (70) begin
      x = $random(seed);
      v = $random(seed);
      @(posedge clk);
      lut_in <= x;
      gpin <= v[5:0];
      #1 chk(io_out, lut_out({8{v[4], fast, slow, v[1]}}));
    end
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 chk({grst, flt, oe}, 10'h300);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h05);
    chk({v[17], v[15:8]}, 9'h0);
    end_sim;
  end
  initial begin
    #30us;
    mismatches++;
    end_sim;
  end
endmodule
